// *** pkg/clk_ctl_pkg.sv ***
// Purpose: shared constants and types for the clock source select and monitor block
// Assumes: AHB-Lite word access, one core clock
// Notes: watched clocks share one 4-bit field layout inside the monitor register
package clk_ctl_pkg;

  // register byte addresses
  localparam logic [31:0] OSC_CTRL_ADDR = 32'h4000_0040;
  localparam logic [31:0] SYS_SEL_ADDR = 32'h4000_0044;
  localparam logic [31:0] MON_ADDR = 32'h4000_0048;

  // reset values
  localparam logic [7:0] OSC_CTRL_RST = 8'h20;
  localparam logic [2:0] SYS_SEL_RST = 3'h0;
  localparam logic [15:0] MON_CTRL_RST = 16'h8000;
  // bits of the monitor register held as plain read/write storage
  localparam logic [15:0] MON_CTRL_RW_MASK = 16'h8ccc;

  // monitor register layout: field base = index * FIELD_W
  localparam int W_MAIN = 0;
  localparam int W_SYS = 1;
  localparam int W_SUB = 2;
  localparam int N_WATCH = 3;
  localparam int FIELD_W = 4;
  localparam int STS_OFS = 0;
  localparam int FAIL_OFS = 1;
  localparam int IE_OFS = 2;
  localparam int WATCH_OFS = 3;
  localparam int FALLBACK_DIS_BIT = 15;

  // main clock source codes
  localparam logic [2:0] SRC_LOW_SPEED_RC = 3'h0;
  localparam logic [2:0] SRC_SUB_CRYSTAL = 3'h1;
  localparam logic [2:0] SRC_HIGH_SPEED_RC = 3'h4;
  localparam logic [2:0] SRC_MAIN_CRYSTAL = 3'h6;

  // oscillator control codes (upper bit clear means off)
  localparam logic [1:0] OSC_RUN = 2'h2;
  localparam logic [1:0] OSC_RUN_DIV2 = 2'h3;

  // reference cycles without an edge before a clock counts as failed
  localparam int REF_MISS_LIMIT = 4;

  typedef struct packed {
    logic [1:0] sub_crystal_ctrl;
    logic [1:0] low_speed_rc_ctrl;
    logic [1:0] high_speed_rc_ctrl;
    logic [1:0] main_crystal_ctrl;
  } osc_ctrl_t;

  // index 3 sub crystal, 2 low-speed rc, 1 high-speed rc, 0 main crystal
  typedef struct packed {
    logic [3:0] en;
    logic [3:0] div2;
  } osc_drive_t;

  typedef struct packed {
    logic ls_rc;
    logic main_crystal;
    logic sysclk;
    logic sub_crystal;
  } clk_sense_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_rsp_t;

  typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} bus_phase_t;

endpackage

// *** src/clock_activity_watch.sv ***
// Purpose: watches one sampled clock level against reference ticks
// Assumes: mon_level and ref_tick are synchronous to clk
// Notes: a clock is dead after MISS_LIMIT reference ticks with no rising edge
module clock_activity_watch #(
  parameter int MISS_LIMIT = clk_ctl_pkg::REF_MISS_LIMIT
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // watch inputs
  input wire logic watch_en,
  input wire logic ref_tick,
  input wire logic mon_level,
  // results
  output logic running,
  output logic fail_pulse
);
  import clk_ctl_pkg::*;

  localparam int CW = $clog2(MISS_LIMIT + 1);
  localparam logic [CW-1:0] LIMIT = CW'(MISS_LIMIT);

  logic prev_q;
  logic fired_q;
  logic [CW-1:0] cnt_q;
  logic mon_edge;
  logic dead;

  assign mon_edge = mon_level & ~prev_q;
  assign dead = (cnt_q == LIMIT);
  assign running = ~dead;
  // one event per failure, also when watching starts on a dead clock
  assign fail_pulse = watch_en & dead & ~fired_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= mon_level;
    end
  end

  // starts dead so status reads zero until the first edge
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= LIMIT;
    end else if (mon_edge) begin
      cnt_q <= '0;
    end else if (ref_tick && !dead) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fired_q <= 1'b0;
    end else begin
      fired_q <= watch_en & dead;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_EDGE_REVIVES: assert property (mon_edge |=> running)
    else $error("clock edge did not mark clock running");
  AST_DEAD_STAYS: assert property (dead && !mon_edge |=> dead)
    else $error("dead clock revived without an edge");
  AST_NO_FAIL_UNWATCHED: assert property (!watch_en |-> !fail_pulse)
    else $error("failure reported while watching is off");

endmodule // clock_activity_watch

// *** src/clock_source_select_monitor.sv ***
// Purpose: oscillator enables, main clock source select and clock failure monitor
// Assumes: clock sense inputs are sampled levels synchronous to CORE_CLK
// Notes: the glitch-free clock mux sits outside; it follows MAIN_CLOCK_SOURCE_SEL

module clock_source_select_monitor #(
  parameter int MISS_LIMIT = clk_ctl_pkg::REF_MISS_LIMIT
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // register bus
  input wire clk_ctl_pkg::ahb_req_t AHB_REQ,
  output clk_ctl_pkg::ahb_rsp_t AHB_RSP,
  // sampled clock levels
  input wire clk_ctl_pkg::clk_sense_t CLK_SENSE,
  // nmi enable held elsewhere
  input wire logic SYSCLK_FAIL_NMI_EN,
  // oscillator and mux control
  output clk_ctl_pkg::osc_drive_t OSC_DRIVE,
  output logic [2:0] MAIN_CLOCK_SOURCE_SEL,
  // events
  output logic IRQ,
  output logic SYSCLK_FAIL_NMI
);
  import clk_ctl_pkg::*;

  bus_phase_t ph_q;
  logic [31:0] addr_q;
  logic [31:0] rdata_q;
  logic readyout_q;
  logic resp_q;
  logic acc;
  logic wr_osc;
  logic wr_sel;
  logic wr_mon;
  logic [31:0] rd_mux;

  osc_ctrl_t osc_q;
  osc_ctrl_t osc_d;
  logic [2:0] sel_q;
  logic [2:0] sel_d;
  logic [15:0] ctl_q;
  logic [15:0] ctl_d;
  logic [N_WATCH-1:0] fail_q;
  logic [N_WATCH-1:0] fail_d;
  logic [N_WATCH-1:0] fail_evt;
  logic [N_WATCH-1:0] running;
  logic [N_WATCH-1:0] watch_en;
  logic [N_WATCH-1:0] irq_en;
  logic [N_WATCH-1:0] mon_lvl;
  logic [15:0] mon_rd;
  logic ls_prev_q;
  logic ref_tick;
  logic fallback;
  osc_drive_t drive_q;
  logic irq_q;
  logic nmi_q;

  //////////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, always okay

  assign acc = AHB_REQ.hready & AHB_REQ.hsel & AHB_REQ.htrans[1];

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ph_q <= PH_IDLE;
      addr_q <= 32'h0000_0000;
    end else if (AHB_REQ.hready) begin
      if (acc) begin
        ph_q <= AHB_REQ.hwrite ? PH_WRITE : PH_READ;
        addr_q <= AHB_REQ.haddr;
      end else begin
        ph_q <= PH_IDLE;
      end
    end
  end

  assign wr_osc = (ph_q == PH_WRITE) && (addr_q == OSC_CTRL_ADDR);
  assign wr_sel = (ph_q == PH_WRITE) && (addr_q == SYS_SEL_ADDR);
  assign wr_mon = (ph_q == PH_WRITE) && (addr_q == MON_ADDR);

  // reads use next values so a write right before is seen
  always_comb begin
    case (AHB_REQ.haddr)
      OSC_CTRL_ADDR: rd_mux = {24'h00_0000, osc_d};
      SYS_SEL_ADDR: rd_mux = {29'h0000_0000, sel_d};
      MON_ADDR: rd_mux = {16'h0000, mon_rd};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rdata_q <= 32'h0000_0000;
    end else if (acc && !AHB_REQ.hwrite) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      readyout_q <= 1'b1;
      resp_q <= 1'b0;
    end else begin
      readyout_q <= 1'b1;
      resp_q <= 1'b0;
    end
  end

  assign AHB_RSP = '{hrdata: rdata_q, hreadyout: readyout_q, hresp: resp_q};

  //////////////////////////////////////////////////////////////////////////////
  // clock watching

  // reference ticks on rising edges of the low-speed rc
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ls_prev_q <= 1'b0;
    end else begin
      ls_prev_q <= CLK_SENSE.ls_rc;
    end
  end

  assign ref_tick = CLK_SENSE.ls_rc & ~ls_prev_q;

  assign mon_lvl[W_MAIN] = CLK_SENSE.main_crystal;
  assign mon_lvl[W_SYS] = CLK_SENSE.sysclk;
  assign mon_lvl[W_SUB] = CLK_SENSE.sub_crystal;

  genvar gi;
  generate
    for (gi = 0; gi < N_WATCH; gi++) begin : g_watch
      assign watch_en[gi] = ctl_q[gi*FIELD_W + WATCH_OFS];
      assign irq_en[gi] = ctl_q[gi*FIELD_W + IE_OFS];
      clock_activity_watch #(
        .MISS_LIMIT(MISS_LIMIT)
      ) u_watch (
        .clk(CORE_CLK),
        .srst(SRST),
        .watch_en(watch_en[gi]),
        .ref_tick(ref_tick),
        .mon_level(mon_lvl[gi]),
        .running(running[gi]),
        .fail_pulse(fail_evt[gi])
      );
    end
  endgenerate

  assign fallback = fail_evt[W_SYS] & ~ctl_q[FALLBACK_DIS_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_comb begin
    osc_d = osc_q;
    if (wr_osc) begin
      osc_d = osc_ctrl_t'(AHB_REQ.hwdata[7:0]);
    end
    // fallback target must oscillate
    if (fallback) begin
      osc_d.low_speed_rc_ctrl[1] = 1'b1;
    end
  end

  // select changes in one register step, never through another code
  always_comb begin
    sel_d = sel_q;
    if (wr_sel) begin
      sel_d = AHB_REQ.hwdata[2:0];
    end
    if (fallback) begin
      sel_d = SRC_LOW_SPEED_RC;
    end
  end

  always_comb begin
    ctl_d = ctl_q;
    if (wr_mon) begin
      ctl_d = AHB_REQ.hwdata[15:0] & MON_CTRL_RW_MASK;
    end
  end

  // sticky flags: set wins over a clearing write
  always_comb begin
    for (int i = 0; i < N_WATCH; i++) begin
      fail_d[i] = fail_evt[i]
                | (fail_q[i] & ~(wr_mon & AHB_REQ.hwdata[i*FIELD_W + FAIL_OFS]));
    end
  end

  always_comb begin
    mon_rd = ctl_d;
    for (int i = 0; i < N_WATCH; i++) begin
      mon_rd[i*FIELD_W + FAIL_OFS] = fail_d[i];
      mon_rd[i*FIELD_W + STS_OFS] = running[i];
    end
    mon_rd[W_SYS*FIELD_W + STS_OFS] = running[W_SYS] & ctl_d[W_SYS*FIELD_W + WATCH_OFS];
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      osc_q <= osc_ctrl_t'(OSC_CTRL_RST);
    end else begin
      osc_q <= osc_d;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      sel_q <= SYS_SEL_RST;
    end else begin
      sel_q <= sel_d;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctl_q <= MON_CTRL_RST;
      fail_q <= '0;
    end else begin
      ctl_q <= ctl_d;
      fail_q <= fail_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  // upper bit enables, lower bit halves only while the upper bit is set
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      drive_q <= '{en: {OSC_CTRL_RST[7], OSC_CTRL_RST[5], OSC_CTRL_RST[3], OSC_CTRL_RST[1]}, div2: 4'h0};
    end else begin
      drive_q.en <= {osc_d.sub_crystal_ctrl[1], osc_d.low_speed_rc_ctrl[1],
                     osc_d.high_speed_rc_ctrl[1], osc_d.main_crystal_ctrl[1]};
      drive_q.div2 <= {osc_d.sub_crystal_ctrl == OSC_RUN_DIV2, osc_d.low_speed_rc_ctrl == OSC_RUN_DIV2,
                       osc_d.high_speed_rc_ctrl == OSC_RUN_DIV2,
                       osc_d.main_crystal_ctrl == OSC_RUN_DIV2};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      irq_q <= 1'b0;
      nmi_q <= 1'b0;
    end else begin
      irq_q <= |(fail_d & ctl_d_ie());
      nmi_q <= fail_d[W_SYS] & SYSCLK_FAIL_NMI_EN;
    end
  end

  function automatic logic [N_WATCH-1:0] ctl_d_ie();
    logic [N_WATCH-1:0] r;
    r = '0;
    for (int i = 0; i < N_WATCH; i++) begin
      r[i] = ctl_d[i*FIELD_W + IE_OFS];
    end
    return r;
  endfunction

  assign OSC_DRIVE = drive_q;
  assign MAIN_CLOCK_SOURCE_SEL = sel_q;
  assign IRQ = irq_q;
  assign SYSCLK_FAIL_NMI = nmi_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  sequence s_sel_write;
    wr_sel && !fallback;
  endsequence

  sequence s_clear_main;
    wr_mon && AHB_REQ.hwdata[FAIL_OFS] && !fail_evt[W_MAIN];
  endsequence

  sequence s_sys_fail_fallback;
    fail_evt[W_SYS] && !ctl_q[FALLBACK_DIS_BIT];
  endsequence

  AST_DRIVE_DECODE: assert property (OSC_DRIVE.en[0] == osc_q.main_crystal_ctrl[1]
    && OSC_DRIVE.div2[3] == (osc_q.sub_crystal_ctrl == OSC_RUN_DIV2))
    else $error("oscillator drive disagrees with control field");
  AST_RESET_LOW_RC: assert property ($past(SRST) |-> OSC_DRIVE.en == 4'h4 && MAIN_CLOCK_SOURCE_SEL == 3'h0)
    else $error("after reset only the low-speed rc should run");
  AST_SEL_WRITE: assert property (s_sel_write |=> MAIN_CLOCK_SOURCE_SEL == $past(AHB_REQ.hwdata[2:0]))
    else $error("select write not applied");
  AST_MAIN_UNWATCHED: assert property ($rose(fail_q[W_MAIN]) |-> $past(watch_en[W_MAIN]))
    else $error("main crystal flagged while not watched");
  AST_FLAG_HOLD: assert property (fail_q[W_MAIN] && !(wr_mon && AHB_REQ.hwdata[FAIL_OFS]) |=> fail_q[W_MAIN])
    else $error("main crystal flag lost without a clear");
  AST_FLAG_CLEAR: assert property (s_clear_main |=> !fail_q[W_MAIN])
    else $error("write one did not clear main crystal flag");
  AST_SET_WINS: assert property (fail_evt[W_SUB] |=> fail_q[W_SUB])
    else $error("sub crystal failure lost against a clear");
  AST_IRQ_LEVEL: assert property (IRQ == |(fail_q & irq_en))
    else $error("interrupt does not follow pending and enable");
  AST_FALLBACK: assert property (s_sys_fail_fallback |=> MAIN_CLOCK_SOURCE_SEL == SRC_LOW_SPEED_RC
    ##1 OSC_DRIVE.en[2])
    else $error("main clock failure did not fall back");
  AST_NO_FALLBACK: assert property (fail_evt[W_SYS] && ctl_q[FALLBACK_DIS_BIT] && !wr_sel |=> $stable(sel_q))
    else $error("select moved with fallback disabled");
  AST_NMI: assert property (SYSCLK_FAIL_NMI == (fail_q[W_SYS] && $past(SYSCLK_FAIL_NMI_EN)))
    else $error("nmi source does not follow main clock flag");
  AST_ZERO_WAIT: assert property (AHB_RSP.hreadyout && !AHB_RSP.hresp)
    else $error("bus answer not ready and okay");

endmodule // clock_source_select_monitor

// *** verification/clock_source_select_monitor_test.sv ***
// Purpose: self-checking bench for the clock source select and monitor block
// Assumes: zero wait state bus, watched clocks toggle each core cycle when running
// Notes: reference ticks every 4 core cycles, miss limit shortened to 2
module clock_source_select_monitor_test import clk_ctl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int MISS = 2;
  logic core_clk, srst, nmi_en, hsel, hwrite, irq, nmi;
  logic [31:0] haddr, hwdata, rd, seed, v;
  logic [1:0] htrans;
  logic [2:0] hsize, sel, run;
  logic [3:0] tick_cnt;
  ahb_req_t ahb_req;
  ahb_rsp_t ahb_rsp;
  clk_sense_t clk_sense;
  osc_drive_t osc_drive;
  int err_count, compares;
  logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h4, 3'h6};

  assign ahb_req = {hsel, haddr, htrans, hwrite, hsize, hwdata, ahb_rsp.hreadyout};

  clock_source_select_monitor #(.MISS_LIMIT(MISS)) dut (
    .CORE_CLK(core_clk),
    .SRST(srst),
    .AHB_REQ(ahb_req),
    .AHB_RSP(ahb_rsp),
    .CLK_SENSE(clk_sense),
    .SYSCLK_FAIL_NMI_EN(nmi_en),
    .OSC_DRIVE(osc_drive),
    .MAIN_CLOCK_SOURCE_SEL(sel),
    .IRQ(irq),
    .SYSCLK_FAIL_NMI(nmi)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // low-speed rc as reference, watched clocks toggle while running
  always @(posedge core_clk) begin
    tick_cnt <= tick_cnt + 4'h1;
    clk_sense <= {tick_cnt[1], run[W_MAIN] & ~clk_sense.main_crystal,
                  run[W_SYS] & ~clk_sense.sysclk, run[W_SUB] & ~clk_sense.sub_crystal};
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ahb_rsp.hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (ahb_rsp.hreadyout !== 1'b1 && n < 100);
    rd = ahb_rsp.hrdata;
    check({31'h0, ahb_rsp.hresp}, 32'h0);
    if (ahb_rsp.hreadyout !== 1'b1) begin
      err_count++;
      test_done();
    end
  endtask

  function automatic osc_drive_t exp_drive(input logic [7:0] c);
    osc_drive_t e;
    for (int i = 0; i < 4; i++) begin
      e.en[i] = c[2 * i + 1];
      e.div2[i] = c[2 * i + 1] & c[2 * i];
    end
    return e;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // enable, run, kill, clear and unwatch one monitored clock
  task automatic watch_test(input int idx);
    int b;
    logic [31:0] base;
    b = idx * FIELD_W;
    base = 32'h8000 | (32'hc << b);
    run[idx] <= 1'b1;
    bus(1'b1, MON_ADDR, base);
    cyc(10);
    bus(1'b0, MON_ADDR, 32'h0);
    check(rd[b + 1 -: 2], 2'h1);
    run[idx] <= 1'b0;
    cyc(8 * MISS + 12);
    bus(1'b0, MON_ADDR, 32'h0);
    check(rd[b + 1 -: 2], 2'h2);
    @(negedge core_clk);
    check({irq, nmi, sel}, {2'h2, SRC_MAIN_CRYSTAL});
    bus(1'b1, MON_ADDR, base);
    bus(1'b0, MON_ADDR, 32'h0);
    check(rd[b + 1], 1'b1);
    bus(1'b1, MON_ADDR, base & ~(32'h4 << b));
    @(negedge core_clk);
    check(irq, 1'b0);
    bus(1'b1, MON_ADDR, base | (32'h2 << b));
    cyc(8 * MISS + 12);
    bus(1'b0, MON_ADDR, 32'h0);
    check(rd[b + 1], 1'b0);
    bus(1'b1, MON_ADDR, 32'h8000);
    run[idx] <= 1'b1;
    cyc(10);
    run[idx] <= 1'b0;
    cyc(8 * MISS + 12);
    bus(1'b0, MON_ADDR, 32'h0);
    check(rd[b + 1], 1'b0);
    run[idx] <= 1'b1;
    cyc(6);
    bus(1'b0, MON_ADDR, 32'h0);
    check(rd[b], idx != W_SYS);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h62488f79;
    srst = 1'b1;
    nmi_en = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    run = 3'h0;
    tick_cnt = 4'h0;
    clk_sense = '0;
    err_count = 0;
    compares = 0;
    cyc(3);
    srst <= 1'b0;
    @(negedge core_clk);
    check({osc_drive, sel, irq, nmi}, {8'h40, 5'h0});
    bus(1'b0, OSC_CTRL_ADDR, 32'h0);
    check(rd, 32'h20);
    bus(1'b0, SYS_SEL_ADDR, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, MON_ADDR, 32'h0);
    check(rd, 32'h8000);
    bus(1'b1, 32'h4000_004c, 32'hffff_ffff);
    bus(1'b0, 32'h4000_004c, 32'h0);
    check(rd, 32'h0);
    // every field code, then random settings
    for (int i = 0; i < 10; i++) begin
      v = (i < 4) ? 32'h55 * i : {24'h0, 8'($random(seed))};
      bus(1'b1, OSC_CTRL_ADDR, v);
      @(negedge core_clk);
      check(osc_drive, exp_drive(v[7:0]));
      bus(1'b0, OSC_CTRL_ADDR, 32'h0);
      check(rd, {24'h0, v[7:0]});
    end
    // all sources running before any select change
    bus(1'b1, OSC_CTRL_ADDR, 32'haa);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, SYS_SEL_ADDR, {29'h0, codes[i]});
      @(negedge core_clk);
      check(sel, codes[i]);
      bus(1'b0, SYS_SEL_ADDR, 32'h0);
      check(rd, {29'h0, codes[i]});
    end
    watch_test(W_MAIN);
    watch_test(W_SUB);
    watch_test(W_SYS);
    // fallback enabled, low-speed rc switched off beforehand
    nmi_en <= 1'b1;
    bus(1'b1, OSC_CTRL_ADDR, 32'h8a);
    bus(1'b1, MON_ADDR, 32'h0080);
    cyc(6);
    run[W_SYS] <= 1'b0;
    cyc(8 * MISS + 12);
    @(negedge core_clk);
    check({sel, osc_drive.en[2], nmi, irq}, {SRC_LOW_SPEED_RC, 3'h6});
    bus(1'b0, MON_ADDR, 32'h0);
    check(rd[5], 1'b1);
    bus(1'b1, MON_ADDR, 32'h00a0);
    cyc(2);
    @(negedge core_clk);
    check(nmi, 1'b0);
    test_done();
  end

endmodule // clock_source_select_monitor_test
